/* File: bench/lssc_host_model.sv */
// Host model driving the register strobe port
`timescale 1ns/100ps
module lssc_host_model (
   input wire logic clk_sys_i,
   input wire logic [7:0] rdata_i,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // Idle port: strobes low
   initial
   begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // One write, held until the taking edge, then bus scrambled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      #1;
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_sys_i);
      #1;
      wr_en_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // One read; an extra edge lets the registered data settle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      #1;
      rd_en_o = 1'b1;
      addr_o = a;
      @(posedge clk_sys_i);
      #1;
      rd_en_o = 1'b0;
      addr_o = ~a;
      @(posedge clk_sys_i);
      #1;
      d = rdata_i;
   endtask
endmodule

/* File: bench/lssc_seq_top_test.sv */
// Self-checking bench for the load switch sequencer
`timescale 1ns/100ps
module lssc_seq_top_test;
   // Short slot base keeps the walks brief
   localparam int BASE = 8;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic wr_en, rd_en, seq_busy;
   logic [7:0] addr, wdata, rdata, rv;
   logic [5:0] ch_on;
   logic [11:0] ramp_code;
   logic [65:0] ramp_us;
   logic [2:0] slot_cnt;
   logic [2:0] fld [6] = '{3'h1, 3'h3, 3'h7, 3'h0, 3'h4, 3'h2};
   logic [7:0] regs [7] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h09};
   int n_mismatch = 0;
   int comparisons = 0;
   int n;
   // ----
   // Harness
   // ----
   always #2 clk_sys_i = ~clk_sys_i;
   lssc_seq_top #(.SLOT_BASE_CYC(BASE)) dut_u (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ch_on_o(ch_on),
      .ramp_code_o(ramp_code), .ramp_us_o(ramp_us),
      .seq_busy_o(seq_busy), .slot_cnt_o(slot_cnt));
   lssc_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
      .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
   // ----
   // Checks and expectations
   // ----
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask
   task automatic chk_port(input logic [65:0] got,
      input logic [65:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, rv);
      chk_reg(rv, e);
   endtask
   // Channel 4 stays on by its direct bit throughout
   function automatic logic [5:0] exp_on(input int k, input logic up);
      exp_on = 6'h08;
      for (int i = 0; i < 6; i++)
         if (fld[i] != 3'h0 && (up ? fld[i] <= k : fld[i] < k))
            exp_on[i] = 1'b1;
   endfunction
   function automatic logic [10:0] us(input logic [1:0] c);
      case (c)
         2'h0: us = 11'h154;
         2'h1: us = 11'h020;
         2'h2: us = 11'h096;
         default: us = 11'h3e8;
      endcase
   endfunction
   // Probe each slot at its middle, then the idle state after it
   task automatic walk(input logic up, input int p);
      int k;
      repeat (p / 2) @(posedge clk_sys_i);
      #1;
      for (int s = 0; s < 7; s++)
      begin
         k = up ? s + 1 : 7 - s;
         chk_port(66'(slot_cnt), 66'(k));
         chk_port(66'(seq_busy), 66'h1);
         chk_port(66'(ch_on), 66'(exp_on(k, up)));
         repeat (p) @(posedge clk_sys_i);
         #1;
      end
      chk_port(66'({seq_busy, slot_cnt}), 66'h0);
      chk_port(66'(ch_on), 66'(exp_on(up ? 7 : 1, up)));
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      #1;
      resetn_i = 1'b1;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      rd_chk(8'h0a, 8'h00);
      chk_port(ramp_us, {6{11'h154}});
      $display("test reset done");
      for (int c = 0; c < 4; c++)
      begin
         host_u.wr(8'h04, c[0] ? 8'hff : 8'h00);
         host_u.wr(8'h09, c[1] ? 8'hff : 8'h00);
         rd_chk(8'h04, c[0] ? 8'h3f : 8'h00);
         rd_chk(8'h09, c[1] ? 8'h3f : 8'h00);
         chk_port(66'(ramp_code), 66'({6{c[1:0]}}));
         chk_port(ramp_us, {6{us(c[1:0])}});
      end
      host_u.wr(8'h04, 8'h01);
      host_u.wr(8'h09, 8'h20);
      chk_port(66'(ramp_code), 66'h801);
      chk_port(ramp_us, {11'h096, {4{11'h154}}, 11'h020});
      $display("test ramp done");
      host_u.wr(8'h02, 8'h2a);
      chk_port(66'(ch_on), 66'h2a);
      host_u.wr(8'h02, 8'h08);
      host_u.wr(8'h05, 8'hff);
      rd_chk(8'h05, 8'h3f);
      host_u.wr(8'h05, 8'h19);
      host_u.wr(8'h06, 8'h07);
      host_u.wr(8'h07, 8'h14);
      rd_chk(8'h07, 8'h14);
      $display("test slot fields done");
      host_u.wr(8'h08, 8'h70);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk_port(66'(seq_busy), 66'h0);
      rd_chk(8'h08, 8'h40);
      host_u.wr(8'h08, 8'h50);
      walk(1'b1, 2 * BASE);
      host_u.wr(8'h08, 8'h20);
      walk(1'b0, BASE);
      rd_chk(8'h08, 8'h00);
      $display("test walks done");
      for (int s = 0; s < 4; s++)
      begin
         host_u.wr(8'h08, {s[1:0], s[0] ? 2'h2 : 2'h1, 4'h0});
         n = 0;
         while (seq_busy === 1'b1 && n < 1000)
         begin
            @(posedge clk_sys_i);
            #1;
            n++;
         end
         chk_port(66'(n), 66'(7 * (s + 1) * BASE));
      end
      $display("test speeds done");
      // Reset in mid-run must clear registers set by the earlier tests
      @(posedge clk_sys_i);
      #1;
      resetn_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      resetn_i = 1'b1;
      chk_port(66'(ch_on), 66'h0);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h05, 8'h00);
      $display("test mid reset done");
      conclude();
   end
   // Tests need about 870 cycles; this allows many times that
   initial
   begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule

/* File: logic/lssc_defs.svh */
// Register map, field positions, reset values and timing for the sequencer
`ifndef LSSC_DEFS_SVH
`define LSSC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSSC_ADDR_DIRECT_ON 8'h02
`define LSSC_ADDR_RAMP_LOW 8'h04
`define LSSC_ADDR_PAIR_A 8'h05
`define LSSC_ADDR_PAIR_B 8'h06
`define LSSC_ADDR_PAIR_C 8'h07
`define LSSC_ADDR_SEQ_CTRL 8'h08
`define LSSC_ADDR_RAMP_HIGH 8'h09
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define LSSC_RST_REG 8'h00
`define LSSC_RST_CH 6'h00
`define LSSC_FLD_EVEN_HI 5
`define LSSC_FLD_EVEN_LO 3
`define LSSC_FLD_ODD_HI 2
`define LSSC_FLD_ODD_LO 0
`define LSSC_FLD_SPEED_HI 7
`define LSSC_FLD_SPEED_LO 6
`define LSSC_FLD_CMD_HI 5
`define LSSC_FLD_CMD_LO 4
`define LSSC_CMD_UP 2'h1
`define LSSC_CMD_DOWN 2'h2
`define LSSC_SLOT_NONE 3'h0
`define LSSC_SLOT_FIRST 3'h1
`define LSSC_SLOT_LAST 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define LSSC_CLK_PERIOD_NS 4
`define LSSC_SLOT_BASE_NS 500000
`define LSSC_SLOT_BASE_CYC (`LSSC_SLOT_BASE_NS / `LSSC_CLK_PERIOD_NS)
`define LSSC_RAMP_US_00 11'h154
`define LSSC_RAMP_US_01 11'h020
`define LSSC_RAMP_US_10 11'h096
`define LSSC_RAMP_US_11 11'h3e8
`endif

/* File: logic/lssc_pkg.sv */
// Types shared by the load switch sequencer
package lssc_pkg;
   typedef enum logic [1:0] {LSSC_IDLE, LSSC_UP, LSSC_DOWN} lssc_state_t;
endpackage

/* File: logic/lssc_seq_top.sv */
// Load switch ramp select, slot assignment and power sequencer
`timescale 1ns/100ps
`include "lssc_defs.svh"
module lssc_seq_top
   import lssc_pkg::*;
#(
   parameter int SLOT_BASE_CYC = `LSSC_SLOT_BASE_CYC,
   parameter int NUM_CH = 6
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic [NUM_CH-1:0] ch_on_o,
   output logic [2*NUM_CH-1:0] ramp_code_o,
   output logic [11*NUM_CH-1:0] ramp_us_o,
   output logic seq_busy_o,
   output logic [2:0] slot_cnt_o
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [NUM_CH-1:0] direct_on_q;
   logic [NUM_CH-1:0] ramp_low_q;
   logic [NUM_CH-1:0] ramp_high_q;
   logic [5:0] pair_q [0:2];
   logic [1:0] speed_q;
   logic [7:0] rdata_q;
   lssc_state_t state_q;
   logic [2:0] slot_q;
   logic [NUM_CH-1:0] seq_ch_q;
   logic [2:0] slot_field [0:NUM_CH-1];
   logic tick;
   logic start_up;
   logic start_dn;
   logic step;
   logic finish;
   logic enter;
   logic dir_up;
   logic [2:0] enter_slot;
   logic [1:0] cmd;

   function automatic logic [10:0] ramp_us(input logic [1:0] code);
      unique case (code)
         2'b00: ramp_us = `LSSC_RAMP_US_00;
         2'b01: ramp_us = `LSSC_RAMP_US_01;
         2'b10: ramp_us = `LSSC_RAMP_US_10;
         2'b11: ramp_us = `LSSC_RAMP_US_11;
      endcase
   endfunction

   // Plain register writes; the command field has no storage
   // ramp registers reset zero
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         direct_on_q <= `LSSC_RST_CH;
         ramp_low_q <= `LSSC_RST_CH;
         ramp_high_q <= `LSSC_RST_CH;
         pair_q[0] <= `LSSC_RST_CH;
         pair_q[1] <= `LSSC_RST_CH;
         pair_q[2] <= `LSSC_RST_CH;
         speed_q <= 2'h0;
      end
      else if (wr_en_i)
      begin
         unique case (addr_i)
            `LSSC_ADDR_DIRECT_ON: direct_on_q <= wdata_i[NUM_CH-1:0];
            `LSSC_ADDR_RAMP_LOW: ramp_low_q <= wdata_i[NUM_CH-1:0];
            `LSSC_ADDR_RAMP_HIGH: ramp_high_q <= wdata_i[NUM_CH-1:0];
            `LSSC_ADDR_PAIR_A: pair_q[0] <= wdata_i[5:0];
            `LSSC_ADDR_PAIR_B: pair_q[1] <= wdata_i[5:0];
            `LSSC_ADDR_PAIR_C: pair_q[2] <= wdata_i[5:0];
            `LSSC_ADDR_SEQ_CTRL:
               speed_q <= wdata_i[`LSSC_FLD_SPEED_HI:`LSSC_FLD_SPEED_LO];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Register reads, one cycle after the strobe
   // ----------------------------------------
   // reserved bits read zero
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rdata_q <= `LSSC_RST_REG;
      else if (rd_en_i)
      begin
         unique case (addr_i)
            `LSSC_ADDR_DIRECT_ON: rdata_q <= {2'b00, direct_on_q};
            `LSSC_ADDR_RAMP_LOW: rdata_q <= {2'b00, ramp_low_q};
            `LSSC_ADDR_RAMP_HIGH: rdata_q <= {2'b00, ramp_high_q};
            `LSSC_ADDR_PAIR_A: rdata_q <= {2'b00, pair_q[0]};
            `LSSC_ADDR_PAIR_B: rdata_q <= {2'b00, pair_q[1]};
            `LSSC_ADDR_PAIR_C: rdata_q <= {2'b00, pair_q[2]};
            `LSSC_ADDR_SEQ_CTRL:
               rdata_q <= {speed_q, 2'b00, seq_busy_o, slot_cnt_o};
            default: rdata_q <= `LSSC_RST_REG;
         endcase
      end
   end
   assign rdata_o = rdata_q;

   // ----------------------------------------
   // Per channel fields and outputs
   // ----------------------------------------
   for (genvar n = 0; n < NUM_CH; n++)
   begin : g_ch
      if (n % 2 == 0)
      begin : g_odd
         assign slot_field[n] =
            pair_q[n/2][`LSSC_FLD_ODD_HI:`LSSC_FLD_ODD_LO];
      end
      else
      begin : g_even
         assign slot_field[n] =
            pair_q[n/2][`LSSC_FLD_EVEN_HI:`LSSC_FLD_EVEN_LO];
      end
      // code from high and low bit
      assign ramp_code_o[2*n+1:2*n] = {ramp_high_q[n], ramp_low_q[n]};
      assign ramp_us_o[11*n+10:11*n] =
         ramp_us({ramp_high_q[n], ramp_low_q[n]});
      assign ch_on_o[n] = (slot_field[n] == `LSSC_SLOT_NONE) ?
         direct_on_q[n] : seq_ch_q[n];

      // Field is looked at only as its slot opens, so later edits wait
      // same slot for on and off
      // field k belongs to slot k
      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
         if (!resetn_i)
            seq_ch_q[n] <= 1'b0;
         else if (enter && slot_field[n] == enter_slot)
            seq_ch_q[n] <= dir_up;
      end
   end

   // ----------------------------------------
   // Sequencer control
   // ----------------------------------------
   assign cmd = wdata_i[`LSSC_FLD_CMD_HI:`LSSC_FLD_CMD_LO];
   // 11 and commands while busy are dropped
   assign start_up = wr_en_i && addr_i == `LSSC_ADDR_SEQ_CTRL &&
      cmd == `LSSC_CMD_UP && state_q == LSSC_IDLE;
   assign start_dn = wr_en_i && addr_i == `LSSC_ADDR_SEQ_CTRL &&
      cmd == `LSSC_CMD_DOWN && state_q == LSSC_IDLE;
   assign finish = tick && ((state_q == LSSC_UP && slot_q == `LSSC_SLOT_LAST)
      || (state_q == LSSC_DOWN && slot_q == `LSSC_SLOT_FIRST));
   assign step = tick && !finish;
   assign enter = start_up || start_dn || step;
   assign dir_up = start_up || state_q == LSSC_UP;
   assign enter_slot = start_up ? `LSSC_SLOT_FIRST :
      start_dn ? `LSSC_SLOT_LAST :
      (state_q == LSSC_UP) ? slot_q + 3'h1 : slot_q - 3'h1;

   // Slot walk in either direction
   // ascending power-up
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_q <= LSSC_IDLE;
         slot_q <= `LSSC_SLOT_NONE;
      end
      else if (start_up)
      begin
         state_q <= LSSC_UP;
         slot_q <= `LSSC_SLOT_FIRST;
      end
      else if (start_dn)
      begin
         state_q <= LSSC_DOWN;
         slot_q <= `LSSC_SLOT_LAST;
      end
      else if (finish)
      begin
         state_q <= LSSC_IDLE;
         slot_q <= `LSSC_SLOT_NONE;
      end
      else if (step)
         slot_q <= enter_slot;
   end

   // active from slot start to end
   assign seq_busy_o = state_q != LSSC_IDLE;
   assign slot_cnt_o = slot_q;

   // timer free runs during a sequence
   lssc_slot_timer #(
      .SLOT_BASE_CYC(SLOT_BASE_CYC)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .run_i(seq_busy_o),
      .speed_i(speed_q),
      .tick_o(tick)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_up_start;
      start_up ##1 (seq_busy_o && slot_cnt_o == 3'h1);
   endsequence

   a_ramp_time_map: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      ramp_code_o[1:0] == 2'b11 |-> ramp_us_o[10:0] == 11'd1000)
      else $error("ramp code 11 not mapped to 1000 us");
   a_ramp_rsvd_zero: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_en_i && addr_i == `LSSC_ADDR_RAMP_HIGH |=> rdata_o[7:6] == 2'b00)
      else $error("ramp reserved bits not zero");
   // Checked at the release edge, where the cleared values must still stand
   a_ramp_reset: assert property (
      @(posedge clk_sys_i)
      $rose(resetn_i) |-> ramp_low_q == 6'h00 && ramp_high_q == 6'h00)
      else $error("ramp registers not cleared by reset");
   a_up_ascend: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      state_q == LSSC_UP && tick && slot_q != 3'h7 |=>
      slot_q == $past(slot_q) + 3'h1)
      else $error("power-up slot did not advance by one");
   a_down_descend: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      state_q == LSSC_DOWN && tick && slot_q != 3'h1 |=>
      slot_q == $past(slot_q) - 3'h1)
      else $error("shutdown slot did not step down by one");
   a_slot_turns_on: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      enter && dir_up && slot_field[0] == enter_slot |=> seq_ch_q[0])
      else $error("channel not switched on in its slot");
   a_slot_turns_off: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      enter && !dir_up && slot_field[0] == enter_slot |=> !seq_ch_q[0])
      else $error("channel not switched off in its slot");
   a_direct_ctrl: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      slot_field[0] == 3'h0 |-> ch_on_o[0] == direct_on_q[0])
      else $error("unassigned channel not following enable bit");
   a_pair_rsvd_zero: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_en_i && addr_i == `LSSC_ADDR_PAIR_C |=> rdata_o[7:6] == 2'b00)
      else $error("slot pair reserved bits not zero");
   a_cmd_reads_zero: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      rd_en_i && addr_i == `LSSC_ADDR_SEQ_CTRL |=> rdata_o[5:4] == 2'b00)
      else $error("command field read back nonzero");
   a_active_start: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      start_up |-> s_up_start)
      else $error("power-up did not open slot 1 as active");
   a_idle_count_zero: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      finish |=> !seq_busy_o && slot_cnt_o == 3'h0)
      else $error("slot count not zero after completion");
endmodule

/* File: logic/lssc_slot_timer.sv */
// Slot period timer: one tick at the end of each slot
`timescale 1ns/100ps
`include "lssc_defs.svh"
module lssc_slot_timer #(
   parameter int SLOT_BASE_CYC = `LSSC_SLOT_BASE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic run_i,
   input wire logic [1:0] speed_i,
   output logic tick_o
);
   logic [21:0] cnt_q;
   logic [21:0] limit;

   // Period is speed plus one base slots
   // slot period select
   assign limit = 22'((32'(speed_i) + 32'd1) * 32'(SLOT_BASE_CYC) - 32'd1);
   assign tick_o = run_i && (cnt_q == limit);

   // Free running while a sequence is active, parked at zero otherwise
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cnt_q <= 22'h00_0000;
      else if (!run_i || tick_o)
         cnt_q <= 22'h00_0000;
      else
         cnt_q <= cnt_q + 22'h00_0001;
   end

   // After a tick the counter restarts from zero and no tick follows in the next cycle
   a_slot_period: assert property (
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (tick_o && run_i) |=> !tick_o [*1] ##0 (cnt_q == 22'h00_0000))
      else $error("slot counter not restarted after tick");
endmodule
